//--- logic/prt_defines.svh
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH

// bus target address
`define PRT_I2C_ADDR          7'h6D

// register offsets
`define PRT_OFS_PRES_HIGH     8'h06
`define PRT_OFS_PRES_MID      8'h07
`define PRT_OFS_PRES_LOW      8'h08
`define PRT_OFS_TEMP_HIGH     8'h09
`define PRT_OFS_TEMP_LOW      8'h0A
`define PRT_OFS_CMD           8'h30
`define PRT_OFS_SYS           8'hA5
`define PRT_OFS_PCH           8'hA6

// command register fields
`define PRT_CMD_SLEEP_MSB     7
`define PRT_CMD_SLEEP_LSB     4
`define PRT_CMD_SCO_BIT       3
`define PRT_CMD_MODE_MSB      2
`define PRT_CMD_MODE_LSB      0
`define PRT_MODE_COMBINED     3'h2
`define PRT_MODE_SLEEP        3'h3
`define PRT_CMD_RESET         8'h00

// system setup fields
`define PRT_SYS_AOUT_MSB      7
`define PRT_SYS_AOUT_LSB      4
`define PRT_SYS_LDO_BIT       3
`define PRT_SYS_UNSIGNED_BIT  2
`define PRT_SYS_RAW_BIT       1
`define PRT_SYS_DIAG_BIT      0
`define PRT_SYS_RESET         8'h01

// pressure channel setup fields
`define PRT_PCH_SWAP_BIT      7
`define PRT_PCH_GAIN_MSB      5
`define PRT_PCH_GAIN_LSB      3
`define PRT_PCH_OSR_MSB       2
`define PRT_PCH_OSR_LSB       0
`define PRT_PCH_RESET         8'h00
`define PRT_PCH_MASK          8'hBF

// timing
`define PRT_CLOCK_MHZ         50
`define PRT_SLEEP_STEP_US     62500
`define PRT_SLEEP_STEP_CYCLES (`PRT_SLEEP_STEP_US * `PRT_CLOCK_MHZ)

`endif

//--- logic/prt_pkg.sv
`default_nettype none
package prt_pkg;

   // bus target states, gray along the usual path
   typedef enum logic [2:0] {
      PRT_I_IDLE     = 3'h0,
      PRT_I_ADDR     = 3'h1,
      PRT_I_ACK_ADDR = 3'h3,
      PRT_I_WRITE    = 3'h2,
      PRT_I_ACK_WR   = 3'h6,
      PRT_I_READ     = 3'h7,
      PRT_I_ACK_RD   = 3'h5
   } prt_i2c_state_t;

   // measurement sequencer states
   typedef enum logic [1:0] {
      PRT_C_IDLE  = 2'h0,
      PRT_C_TEMP  = 2'h1,
      PRT_C_PRES  = 2'h3,
      PRT_C_SLEEP = 2'h2
   } prt_conv_state_t;

endpackage
`default_nettype wire

//--- logic/prt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module prt_sync
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       enable,
   // pins
   input  wire logic [1:0] async_in,
   output logic      [1:0] sync_out
);

   logic [1:0] meta_ff;

   // two stages; the first is read by the second only
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         meta_ff  <= 2'h3;
         sync_out <= 2'h3;
      end
      else if (enable)
      begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule
`default_nettype wire

//--- logic/prt_sleep_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prt_defines.svh"
module prt_sleep_timer
#(
   parameter int unsigned STEP_CYCLES = `PRT_SLEEP_STEP_CYCLES
)
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       enable,
   // control
   input  wire logic       start,
   input  wire logic [3:0] code,
   output logic            done
);

   logic [31:0] cnt_ff;
   logic [3:0]  steps_ff;
   logic [3:0]  code_ff;
   logic        run_ff;

   // counts code steps of one step period each; code zero ends at once
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cnt_ff   <= 32'h0;
         steps_ff <= 4'h0;
         code_ff  <= 4'h0;
         run_ff   <= 1'b0;
         done     <= 1'b0;
      end
      else if (enable)
      begin
         done <= 1'b0;
         if (start)
         begin
            cnt_ff   <= 32'h0;
            steps_ff <= 4'h0;
            code_ff  <= code;
            run_ff   <= (code != 4'h0);
            done     <= (code == 4'h0);
         end
         else if (run_ff)
         begin
            if (cnt_ff == STEP_CYCLES - 1)
            begin
               cnt_ff <= 32'h0;
               if (steps_ff == code_ff - 4'h1)
               begin
                  run_ff <= 1'b0;
                  done   <= 1'b1;
               end
               else
                  steps_ff <= steps_ff + 4'h1;
            end
            else
               cnt_ff <= cnt_ff + 32'h1;
         end
      end
   end

endmodule
`default_nettype wire

//--- logic/prt_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "prt_defines.svh"
module prt_readout
#(
   parameter int unsigned SLEEP_STEP_CYCLES = `PRT_SLEEP_STEP_CYCLES,
   parameter logic [7:0]  SYS_SETUP_RESET   = `PRT_SYS_RESET,
   parameter logic [7:0]  PCH_SETUP_RESET   = `PRT_PCH_RESET
)
(
   // clock, reset, enable
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire logic                     enable,
   // bus pins
   input  wire logic                     scl,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe,
   // converter front end
   output logic                          adc_start,
   output logic                          adc_select_pressure,
   input  wire logic                     adc_done,
   input  wire logic [23:0]              adc_data,
   // configuration to the analog side
   output logic                          regulator_voltage_select,
   output logic                          result_unsigned,
   output logic                          raw_output,
   output logic                          diag_enable,
   output logic [3:0]                    analog_out_setting,
   output logic                          input_swap,
   output logic [7:0]                    channel_gain,
   output logic [15:0]                   oversample_ratio,
   // status
   output prt_pkg::prt_conv_state_t      conversion_phase
);
   import prt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic [7:0] gain_of(input logic [2:0] code);
      gain_of = 8'h01 << code;
   endfunction

   function automatic logic [15:0] ratio_of(input logic [2:0] code);
      case (code)
         3'h0:    ratio_of = 16'h0400;
         3'h1:    ratio_of = 16'h0800;
         3'h2:    ratio_of = 16'h1000;
         3'h3:    ratio_of = 16'h2000;
         3'h4:    ratio_of = 16'h0100;
         3'h5:    ratio_of = 16'h0200;
         3'h6:    ratio_of = 16'h4000;
         default: ratio_of = 16'h8000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [23:0]     pressure_ff;
   logic [15:0]     temp_ff;
   logic [15:0]     temp_hold_ff;
   logic [7:0]      cmd_ff;
   logic [7:0]      sys_ff;
   logic [7:0]      pch_ff;
   logic [1:0]      pins_s;
   logic            scl_s;
   logic            sda_s;
   logic            scl_q_ff;
   logic            sda_q_ff;
   prt_i2c_state_t  i2c_st_ff;
   prt_conv_state_t conv_st_ff;
   logic [3:0]      bit_cnt_ff;
   logic [7:0]      rx_ff;
   logic [7:0]      tx_ff;
   logic [7:0]      ptr_ff;
   logic            rw_ff;
   logic            first_ff;
   logic            mack_ff;
   logic            wr_stb_ff;
   logic [7:0]      wr_addr_ff;
   logic [7:0]      wr_data_ff;
   logic [7:0]      rd_byte;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_cond;
   logic            stop_cond;
   logic            sco;
   logic [2:0]      mode;
   logic            mode_ok;
   logic            commit;
   logic            sco_clear;
   logic            tmr_start;
   logic            tmr_done;

   ////////////////////////////////////////////////////////////////////////
   // pin sampling and bus conditions

   prt_sync u_sync
   (
      .clock    (clock),
      .reset    (reset),
      .enable   (enable),
      .async_in ({scl, sda_in}),
      .sync_out (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // previous sample for edge finding
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else if (enable)
      begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
      end
   end

   // sda moving while scl high marks start and stop
   assign scl_rise   = scl_s & ~scl_q_ff;
   assign scl_fall   = ~scl_s & scl_q_ff;
   assign start_cond = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign stop_cond  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   assign sda_out    = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // register read decode, unmapped offsets read zero

   always_comb
   begin
      case (ptr_ff)
         `PRT_OFS_PRES_HIGH: rd_byte = pressure_ff[23:16];
         `PRT_OFS_PRES_MID:  rd_byte = pressure_ff[15:8];
         `PRT_OFS_PRES_LOW:  rd_byte = pressure_ff[7:0];
         `PRT_OFS_TEMP_HIGH: rd_byte = temp_ff[15:8];
         `PRT_OFS_TEMP_LOW:  rd_byte = temp_ff[7:0];
         `PRT_OFS_CMD:       rd_byte = cmd_ff;
         `PRT_OFS_SYS:       rd_byte = sys_ff;
         `PRT_OFS_PCH:       rd_byte = pch_ff;
         default:            rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // bus target: address, pointer byte, writes and auto-increment reads

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         i2c_st_ff  <= PRT_I_IDLE;
         bit_cnt_ff <= 4'h0;
         rx_ff      <= 8'h00;
         tx_ff      <= 8'h00;
         ptr_ff     <= 8'h00;
         rw_ff      <= 1'b0;
         first_ff   <= 1'b0;
         mack_ff    <= 1'b0;
         sda_oe     <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end
      else if (enable)
      begin
         wr_stb_ff <= 1'b0;
         if (start_cond)
         begin
            i2c_st_ff  <= PRT_I_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe     <= 1'b0;
         end
         else if (stop_cond)
         begin
            i2c_st_ff <= PRT_I_IDLE;
            sda_oe    <= 1'b0;
         end
         else
         begin
            case (i2c_st_ff)
               PRT_I_ADDR:
               begin
                  if (scl_rise)
                  begin
                     rx_ff      <= {rx_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_ff == 4'h8)
                  begin
                     if (rx_ff[7:1] == `PRT_I2C_ADDR)
                     begin
                        i2c_st_ff <= PRT_I_ACK_ADDR;
                        sda_oe    <= 1'b1;
                        rw_ff     <= rx_ff[0];
                     end
                     else
                        i2c_st_ff <= PRT_I_IDLE;
                  end
               end
               PRT_I_ACK_ADDR:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_ff <= 4'h0;
                     if (rw_ff)
                     begin
                        tx_ff     <= rd_byte;
                        sda_oe    <= ~rd_byte[7];
                        ptr_ff    <= ptr_ff + 8'h01;
                        i2c_st_ff <= PRT_I_READ;
                     end
                     else
                     begin
                        sda_oe    <= 1'b0;
                        first_ff  <= 1'b1;
                        i2c_st_ff <= PRT_I_WRITE;
                     end
                  end
               end
               PRT_I_WRITE:
               begin
                  if (scl_rise)
                  begin
                     rx_ff      <= {rx_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_ff == 4'h8)
                  begin
                     sda_oe    <= 1'b1;
                     i2c_st_ff <= PRT_I_ACK_WR;
                     if (first_ff)
                        ptr_ff <= rx_ff;
                     else
                     begin
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= rx_ff;
                        ptr_ff     <= ptr_ff + 8'h01;
                     end
                  end
               end
               PRT_I_ACK_WR:
               begin
                  if (scl_fall)
                  begin
                     sda_oe     <= 1'b0;
                     first_ff   <= 1'b0;
                     bit_cnt_ff <= 4'h0;
                     i2c_st_ff  <= PRT_I_WRITE;
                  end
               end
               PRT_I_READ:
               begin
                  if (scl_rise)
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  else if (scl_fall)
                  begin
                     if (bit_cnt_ff == 4'h8)
                     begin
                        sda_oe    <= 1'b0;
                        i2c_st_ff <= PRT_I_ACK_RD;
                     end
                     else
                     begin
                        tx_ff  <= {tx_ff[6:0], 1'b0};
                        sda_oe <= ~tx_ff[6];
                     end
                  end
               end
               PRT_I_ACK_RD:
               begin
                  // a host nack ends the read; ack fetches the next offset
                  if (scl_rise)
                     mack_ff <= ~sda_s;
                  else if (scl_fall)
                  begin
                     if (mack_ff)
                     begin
                        tx_ff      <= rd_byte;
                        sda_oe     <= ~rd_byte[7];
                        ptr_ff     <= ptr_ff + 8'h01;
                        bit_cnt_ff <= 4'h0;
                        i2c_st_ff  <= PRT_I_READ;
                     end
                     else
                        i2c_st_ff <= PRT_I_IDLE;
                  end
               end
               default:
                  i2c_st_ff <= PRT_I_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file; a host write wins over the self-clear of the flag

   assign sco  = cmd_ff[`PRT_CMD_SCO_BIT];
   assign mode = cmd_ff[`PRT_CMD_MODE_MSB:`PRT_CMD_MODE_LSB];

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pressure_ff <= 24'h000000;
         temp_ff     <= 16'h0000;
         cmd_ff      <= `PRT_CMD_RESET;
         sys_ff      <= SYS_SETUP_RESET;
         pch_ff      <= PCH_SETUP_RESET & `PRT_PCH_MASK;
      end
      else if (enable)
      begin
         if (commit)
         begin
            pressure_ff <= adc_data;
            temp_ff     <= temp_hold_ff;
         end
         // only a command write may override the self-clear, so it comes last
         if (sco_clear)
            cmd_ff[`PRT_CMD_SCO_BIT] <= 1'b0;
         if (wr_stb_ff)
         begin
            case (wr_addr_ff)
               `PRT_OFS_CMD: cmd_ff <= wr_data_ff;
               `PRT_OFS_SYS: sys_ff <= wr_data_ff;
               `PRT_OFS_PCH: pch_ff <= wr_data_ff & `PRT_PCH_MASK;
               default:      pch_ff <= pch_ff; // result bytes are read only
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // measurement sequencer

   assign mode_ok   = (mode == `PRT_MODE_COMBINED) || (mode == `PRT_MODE_SLEEP);
   assign commit    = (conv_st_ff == PRT_C_PRES) && adc_done;
   // sleep mode keeps the flag; unknown modes drop it without converting
   assign sco_clear = (commit && mode != `PRT_MODE_SLEEP) ||
                      (conv_st_ff == PRT_C_IDLE && sco && !mode_ok);
   assign tmr_start = commit && mode == `PRT_MODE_SLEEP && sco;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         conv_st_ff          <= PRT_C_IDLE;
         adc_start           <= 1'b0;
         adc_select_pressure <= 1'b0;
         temp_hold_ff        <= 16'h0000;
      end
      else if (enable)
      begin
         adc_start <= 1'b0;
         case (conv_st_ff)
            PRT_C_IDLE:
            begin
               if (sco && mode_ok)
               begin
                  adc_start           <= 1'b1;
                  adc_select_pressure <= 1'b0;
                  conv_st_ff          <= PRT_C_TEMP;
               end
            end
            PRT_C_TEMP:
            begin
               if (adc_done)
               begin
                  temp_hold_ff        <= adc_data[15:0];
                  adc_start           <= 1'b1;
                  adc_select_pressure <= 1'b1;
                  conv_st_ff          <= PRT_C_PRES;
               end
            end
            PRT_C_PRES:
            begin
               if (adc_done)
                  conv_st_ff <= tmr_start ? PRT_C_SLEEP : PRT_C_IDLE;
            end
            PRT_C_SLEEP:
            begin
               // clearing the flag in sleep mode stops the cycle here
               if (!sco)
                  conv_st_ff <= PRT_C_IDLE;
               else if (tmr_done)
               begin
                  adc_start           <= 1'b1;
                  adc_select_pressure <= 1'b0;
                  conv_st_ff          <= PRT_C_TEMP;
               end
            end
            default:
               conv_st_ff <= PRT_C_IDLE;
         endcase
      end
   end

   // interval is started only by a conversion in sleep mode
   prt_sleep_timer #(.STEP_CYCLES(SLEEP_STEP_CYCLES)) u_timer
   (
      .clock  (clock),
      .reset  (reset),
      .enable (enable),
      .start  (tmr_start),
      .code   (cmd_ff[`PRT_CMD_SLEEP_MSB:`PRT_CMD_SLEEP_LSB]),
      .done   (tmr_done)
   );

   assign conversion_phase = conv_st_ff;

   ////////////////////////////////////////////////////////////////////////
   // configuration decode

   assign regulator_voltage_select = sys_ff[`PRT_SYS_LDO_BIT];
   assign raw_output               = sys_ff[`PRT_SYS_RAW_BIT];
   // unsigned format is meaningless on calibrated data
   assign result_unsigned = sys_ff[`PRT_SYS_UNSIGNED_BIT] & sys_ff[`PRT_SYS_RAW_BIT];
   assign diag_enable        = sys_ff[`PRT_SYS_DIAG_BIT];
   assign analog_out_setting = sys_ff[`PRT_SYS_AOUT_MSB:`PRT_SYS_AOUT_LSB];
   assign input_swap         = pch_ff[`PRT_PCH_SWAP_BIT];
   assign channel_gain       = gain_of(pch_ff[`PRT_PCH_GAIN_MSB:`PRT_PCH_GAIN_LSB]);
   assign oversample_ratio   = ratio_of(pch_ff[`PRT_PCH_OSR_MSB:`PRT_PCH_OSR_LSB]);

   ////////////////////////////////////////////////////////////////////////
   // assertions

   a_result_commit: assert property (@(posedge clock) disable iff (reset || !enable)
      commit |=> (pressure_ff == $past(adc_data) && temp_ff == $past(temp_hold_ff)))
      else $error("result bytes not loaded together at commit");

   a_temp_then_pres: assert property (@(posedge clock) disable iff (reset || !enable)
      (conv_st_ff == PRT_C_TEMP && adc_done) |=> (adc_start && adc_select_pressure))
      else $error("pressure conversion did not follow temperature");

   a_sco_selfclear: assert property (@(posedge clock) disable iff (reset || !enable)
      (commit && mode == `PRT_MODE_COMBINED && !wr_stb_ff) |=> !sco)
      else $error("start flag not cleared after combined conversion");

   a_sleep_keeps: assert property (@(posedge clock) disable iff (reset || !enable)
      (commit && mode == `PRT_MODE_SLEEP && sco && !wr_stb_ff)
      |=> (sco && conv_st_ff == PRT_C_SLEEP))
      else $error("sleep mode conversion did not enter the wait");

   a_sleep_pause: assert property (@(posedge clock) disable iff (reset || !enable)
      (tmr_start && cmd_ff[`PRT_CMD_SLEEP_MSB:`PRT_CMD_SLEEP_LSB] != 4'h0)
      |=> (!adc_start)[*2])
      else $error("sleep interval skipped");

   a_ratio_map: assert property (@(posedge clock) disable iff (reset || !enable)
      (pch_ff[`PRT_PCH_OSR_MSB:`PRT_PCH_OSR_LSB] == 3'h4) |-> (oversample_ratio == 16'h0100))
      else $error("oversample code 100 not mapped to 256");

   a_gain_top: assert property (@(posedge clock) disable iff (reset || !enable)
      (pch_ff[`PRT_PCH_GAIN_MSB:`PRT_PCH_GAIN_LSB] == 3'h7) |-> (channel_gain == 8'h80))
      else $error("gain code 111 not 128");

   a_unsigned_raw: assert property (@(posedge clock) disable iff (reset || !enable)
      result_unsigned |-> raw_output)
      else $error("unsigned output without raw data");

   a_ack_address: assert property (@(posedge clock) disable iff (reset || !enable)
      (i2c_st_ff == PRT_I_ACK_ADDR) |-> (sda_oe && rx_ff[7:1] == `PRT_I2C_ADDR))
      else $error("address acknowledged for wrong target");

   a_temp_bytes: assert property (@(posedge clock) disable iff (reset || !enable)
      (ptr_ff == `PRT_OFS_TEMP_LOW) |-> (rd_byte == temp_ff[7:0]))
      else $error("temperature low byte at wrong offset");

endmodule
`default_nettype wire

//--- testbench/prt_host.sv
`timescale 1ns/1ps
`default_nettype none
module prt_host
(
   // bus pins
   output logic      scl = 1'b1,
   output logic      host_oe = 1'b0,
   input  wire logic sda
);
   // one bit per 160 ns; sda moves only while scl is low
   task automatic bit_io(input logic b, output logic r);
      host_oe = !b;
      #40 scl = 1;
      #40 r = sda;
      #40 scl = 0;
      #40;
   endtask
   // start: the long low gives the target time to drop its ack
   task automatic start();
      host_oe = 0;
      #80 scl = 1;
      #40 host_oe = 1;
      #40 scl = 0;
      #40;
   endtask
   // stop: sda rises while scl is high
   task automatic stop();
      host_oe = 1;
      #40 scl = 1;
      #40 host_oe = 0;
      #80;
   endtask
   // eight bits, msb first, then the ninth bit
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic ak);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, ak);
   endtask
endmodule
`default_nettype wire

//--- testbench/pressure_temp_readout_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pressure_temp_readout_regs_bench;
   localparam logic [15:0] OSR [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
                                       16'h0100, 16'h0200, 16'h4000, 16'h8000};
   logic       clock, reset, scl, host_oe, sda_oe, adc_start, adc_select_pressure;
   logic       regulator_voltage_select, result_unsigned, raw_output, diag_enable;
   logic       input_swap;
   logic       sda_out;
   logic [3:0] analog_out_setting;
   logic [1:0] conversion_phase;
   logic [7:0] channel_gain;
   logic [15:0] oversample_ratio;
   logic [2:0] dly = 3'h0;
   logic [7:0] cnt = 8'h00;
   logic [7:0] buf_q [5];
   int         gap = 0, last_gap = 0, n_temp = 0, error_cnt = 0, total_checks = 0;
   wire        sda = !(sda_oe | host_oe);
   wire        adc_done = dly[2];
   wire [23:0] adc_data = adc_select_pressure ? {16'h805A, cnt} : {16'h007F, cnt};
   prt_readout #(.SLEEP_STEP_CYCLES(4)) i_prt_readout
   (
      .clock, .reset, .enable(1'b1), .scl, .sda_in(sda), .sda_out, .sda_oe,
      .adc_start, .adc_select_pressure, .adc_done, .adc_data,
      .regulator_voltage_select, .result_unsigned, .raw_output, .diag_enable,
      .analog_out_setting, .input_swap, .channel_gain, .oversample_ratio,
      .conversion_phase
   );
   prt_host i_prt_host (.scl, .host_oe, .sda);
   ////////////////////////////////////////
   // converter model answers three cycles late; gap counts sleep spacing
   always @(posedge clock)
   begin
      dly <= #1 {dly[1:0], adc_start};
      cnt <= #1 cnt + adc_done;
      gap <= #1 (adc_done && adc_select_pressure) ? 0 : gap + 1;
      if (adc_start && !adc_select_pressure)
      begin
         n_temp <= #1 n_temp + 1;
         last_gap <= #1 gap;
      end
   end
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       ak;
      @(posedge clock) #1 i_prt_host.start();
      i_prt_host.xfer(8'hDA, 1'b1, q, ak);
      i_prt_host.xfer(a, 1'b1, q, ak);
      i_prt_host.xfer(d, 1'b1, q, ak);
      i_prt_host.stop();
   endtask
   // pointer write, repeated start, then n bytes, nack on the last
   task automatic rd(input logic [7:0] a, input int n);
      logic ak;
      @(posedge clock) #1 i_prt_host.start();
      i_prt_host.xfer(8'hDA, 1'b1, buf_q[0], ak);
      i_prt_host.xfer(a, 1'b1, buf_q[0], ak);
      i_prt_host.start();
      i_prt_host.xfer(8'hDB, 1'b1, buf_q[0], ak);
      for (int i = 0; i < n; i++)
         i_prt_host.xfer(8'hFF, i == n - 1, buf_q[i], ak);
      i_prt_host.stop();
   endtask
   task automatic wait_temp(input int n);
      int t;
      t = n_temp + n;
      for (int k = 0; k < 3000 && n_temp < t; k++)
         @(posedge clock);
   endtask
   task automatic final_report();
      if (error_cnt == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(8'h06, 5);
      for (int i = 0; i < 5; i++)
         check("result", buf_q[i], 8'h00);
      rd(8'hA5, 2);
      check("sys", buf_q[0], 8'h01);
      check("pch", buf_q[1], 8'h00);
      check("diag", diag_enable, 1'b1);
      check("raw", raw_output, 1'b0);
      check("sda_out", sda_out, 1'b0);
   endtask
   task automatic t_addr();
      logic [7:0] q;
      logic       ak;
      @(posedge clock) #1 i_prt_host.start();
      i_prt_host.xfer(8'hD8, 1'b1, q, ak);
      check("nack", ak, 1'b1);
      i_prt_host.stop();
      @(posedge clock) #1 i_prt_host.start();
      i_prt_host.xfer(8'hDA, 1'b1, q, ak);
      check("ack", ak, 1'b0);
      i_prt_host.stop();
   endtask
   task automatic t_single();
      wr(8'h30, 8'h0A);
      buf_q[0] = 8'h08;
      for (int k = 0; k < 20 && buf_q[0][3] !== 1'b0; k++)
         rd(8'h30, 1);
      check("cmd", buf_q[0], 8'h02);
      check("phase", conversion_phase, 2'h0);
      wr(8'h06, 8'h55);
      rd(8'h06, 5);
      check("p_hi", buf_q[0], 8'h80);
      check("p_mid", buf_q[1], 8'h5A);
      check("t_hi", buf_q[3], 8'h7F);
      check("order", buf_q[2], buf_q[4] + 8'h01);
      check("p_pa", (int'({buf_q[0], buf_q[1], buf_q[2]}) - 2**24) / 4096, -2042);
      check("t_deg", $signed({buf_q[3], buf_q[4]}) / 256, 127);
      rd(8'h40, 1);
      check("unmapped", buf_q[0], 8'h00);
   endtask
   task automatic t_cfg();
      wr(8'hA5, 8'hAE);
      check("aout", analog_out_setting, 4'hA);
      check("ldo", regulator_voltage_select, 1'b1);
      check("uns", result_unsigned, 1'b1);
      check("raw", raw_output, 1'b1);
      check("diag", diag_enable, 1'b0);
      wr(8'hA5, 8'h04);
      check("uns", result_unsigned, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         wr(8'hA6, {i[0], 1'b1, i[2:0], i[2:0]});
         check("swap", input_swap, i[0]);
         check("gain", channel_gain, 8'h01 << i);
         check("osr", oversample_ratio, OSR[i]);
         rd(8'hA6, 1);
         check("pch", buf_q[0], {i[0], 1'b0, i[2:0], i[2:0]});
      end
   endtask
   // sleep spacing must grow by one step of 4 cycles per code
   task automatic t_sleep();
      int g1;
      wr(8'h30, 8'h1B);
      wait_temp(3);
      g1 = last_gap;
      rd(8'h30, 1);
      check("sco", buf_q[0], 8'h1B);
      wr(8'h30, 8'h3B);
      wait_temp(3);
      check("sleep", last_gap - g1, 8);
      wr(8'h30, 8'h00);
      g1 = n_temp;
      repeat (200) @(posedge clock);
      check("stop", n_temp - g1, 0);
   endtask
   ////////////////////////////////////////
   initial
   begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   initial
   begin
      #1000000;
      error_cnt++;
      final_report();
   end
   initial
   begin
      reset = 1;
      repeat (16) @(posedge clock);
      #1 reset = 0;
      repeat (4) @(posedge clock);
      t_reset();
      t_addr();
      t_single();
      t_cfg();
      t_sleep();
      final_report();
   end
endmodule
`default_nettype wire
